// ===== design/oxa_alarm_cal.sv
`timescale 1ns/10ps
module oxa_alarm_cal #(
   parameter int SEC_CYCLES = oxa_pkg::CLK_HZ,
   parameter int PURGE_S    = oxa_pkg::PURGE_S,
   parameter int SAMPLE_S   = oxa_pkg::SAMPLE_S
) (
   input  wire  logic                          clk,
   input  wire  logic                          rst_n,
   input  wire  logic [oxa_pkg::VAL_W-1:0]     meas_value,
   input  wire  logic                          meas_valid,
   input  wire  oxa_pkg::oxa_keys_t            key_press,
   input  wire  oxa_pkg::oxa_keys_t            key_held,
   input  wire  logic                          edit_enter,
   input  wire  logic [1:0]                    cfg_wr,
   input  wire  oxa_pkg::oxa_alm_cfg_t         cfg_data,
   input  wire  logic                          cal_set_wr,
   input  wire  logic [oxa_pkg::VAL_W-1:0]     cal_low_in,
   input  wire  logic [oxa_pkg::VAL_W-1:0]     cal_high_in,
   input  wire  logic                          row_shows_alarms,
   output logic [1:0]                          relay_reg,
   output logic                                first_alarm_indication_reg,
   output logic                                second_alarm_indication_reg,
   output logic [oxa_pkg::VAL_W-1:0]           disp_value_reg,
   output logic                                edit_active_reg,
   output logic                                prot_level_reg,
   output logic                                low_gas_prompt_reg,
   output logic                                high_gas_prompt_reg,
   output logic                                cal_busy_reg,
   output logic                                cal_purge_reg,
   output logic                                cal_done_reg,
   output logic                                cfg_refused_reg,
   output logic [oxa_pkg::VAL_W-1:0]           cal_low_reg,
   output logic [oxa_pkg::VAL_W-1:0]           cal_high_reg,
   output oxa_pkg::oxa_alm_cfg_t               alm_cfg_reg [2]
);

   // ==========================================================
   // parameter checks
   generate
      if (SEC_CYCLES < 2 || PURGE_S < 1 || SAMPLE_S < 1 || PURGE_S > 1023 || SAMPLE_S > 1023) begin : g_bad
         $error("oxa_alarm_cal: timing parameters out of range");
      end
   endgenerate

   typedef enum logic [2:0] {
      OXA_CAL_IDLE   = 3'h0,
      OXA_CAL_PR_LO  = 3'h1,
      OXA_CAL_PR_HI  = 3'h2,
      OXA_CAL_PURGE  = 3'h3,
      OXA_CAL_SAMPLE = 3'h4
   } oxa_cal_state_t;

   // ==========================================================
   // seconds timebase
   logic [31:0]                  sec_cnt_reg;
   logic                         sec_tick_reg;
   logic                         blink_reg;
   logic                         any_key;

   assign any_key = key_press.f | key_press.up | key_press.down | key_press.hidden;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt_reg  <= 32'h0000_0000;
         sec_tick_reg <= 1'b0;
         blink_reg    <= 1'b0;
      end else begin
         sec_tick_reg <= 1'b0;
         if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
            sec_cnt_reg  <= 32'h0000_0000;
            sec_tick_reg <= 1'b1;
            blink_reg    <= ~blink_reg;
         end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // edit and protected level timeouts
   logic [oxa_pkg::SEC_W-1:0]    edit_idle_reg;
   logic [oxa_pkg::SEC_W-1:0]    prot_idle_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edit_active_reg <= 1'b0;
         edit_idle_reg   <= '0;
      end else if (edit_enter) begin
         edit_active_reg <= 1'b1;
         edit_idle_reg   <= '0;
      end else if (any_key) begin
         edit_idle_reg <= '0;
      end else if (edit_active_reg && sec_tick_reg) begin
         if (edit_idle_reg == oxa_pkg::EDIT_TIMEOUT_S - 1'b1) begin
            edit_active_reg <= 1'b0;                                   // see R5
            edit_idle_reg   <= '0;
         end else begin
            edit_idle_reg <= edit_idle_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_level_reg <= 1'b0;
         prot_idle_reg  <= '0;
      end else if (key_press.hidden) begin
         prot_level_reg <= ~prot_level_reg;
         prot_idle_reg  <= '0;
      end else if (any_key) begin
         prot_idle_reg <= '0;
      end else if (prot_level_reg && sec_tick_reg) begin
         if (prot_idle_reg == oxa_pkg::PROT_TIMEOUT_S - 1'b1) begin
            prot_level_reg <= 1'b0;                                    // see R13
            prot_idle_reg  <= '0;
         end else begin
            prot_idle_reg <= prot_idle_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // settings
   logic                         cfg_in_range;
   logic                         cal_ratio_ok;
   logic [oxa_pkg::VAL_W+2:0]    cal_low_x5;

   // out-of-range writes are dropped; no other plausibility check
   assign cfg_in_range = cfg_data.limit >= oxa_pkg::LIMIT_MIN && cfg_data.limit <= oxa_pkg::LIMIT_MAX
                         && cfg_data.hyst >= oxa_pkg::HYST_MIN && cfg_data.hyst <= oxa_pkg::HYST_MAX
                         && cfg_data.delay >= oxa_pkg::DLY_MIN && cfg_data.delay <= oxa_pkg::DLY_MAX;
   assign cal_low_x5   = (oxa_pkg::VAL_W+3)'(cal_low_in) * (oxa_pkg::VAL_W+3)'(oxa_pkg::CAL_RATIO);
   assign cal_ratio_ok = (oxa_pkg::VAL_W+3)'(cal_high_in) >= cal_low_x5;

   for (genvar i = 0; i < 2; i++) begin : g_cfg
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            alm_cfg_reg[i] <= oxa_pkg::ALM_CFG_RST;
         end else if (cfg_wr[i] && cfg_in_range) begin                 // see R1, R14
            if (edit_active_reg) begin
               alm_cfg_reg[i].limit     <= cfg_data.limit;
               alm_cfg_reg[i].high_type <= cfg_data.high_type;          // see R2
            end
            if (prot_level_reg) begin
               alm_cfg_reg[i].mode  <= cfg_data.mode;                   // see R6
               alm_cfg_reg[i].hyst  <= cfg_data.hyst;                   // see R10
               alm_cfg_reg[i].delay <= cfg_data.delay;                  // see R12
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_low_reg     <= oxa_pkg::CAL_LOW_RST;
         cal_high_reg    <= oxa_pkg::CAL_HIGH_RST;
         cfg_refused_reg <= 1'b0;
      end else begin
         cfg_refused_reg <= 1'b0;
         if (cal_set_wr) begin
            if (cal_ratio_ok) begin
               cal_low_reg  <= cal_low_in;
               cal_high_reg <= cal_high_in;
            end else begin
               cfg_refused_reg <= 1'b1;                                // see R17
            end
         end
      end
   end

   // ==========================================================
   // calibration sequencer
   oxa_cal_state_t               cal_state_reg;
   logic [9:0]                   cal_secs_reg;
   logic                         cal_frozen;

   // low-then-high order is advice only; either start is taken (see R21)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_state_reg <= OXA_CAL_IDLE;
         cal_secs_reg  <= '0;
         cal_done_reg  <= 1'b0;
      end else begin
         cal_done_reg <= 1'b0;
         case (cal_state_reg)
            OXA_CAL_IDLE: begin
               if (key_press.f && key_held.down) begin
                  cal_state_reg <= OXA_CAL_PR_LO;                      // see R18
               end else if (key_press.f && key_held.up) begin
                  cal_state_reg <= OXA_CAL_PR_HI;                      // see R19
               end
            end
            OXA_CAL_PR_LO, OXA_CAL_PR_HI: begin
               if (key_press.f) begin
                  cal_state_reg <= OXA_CAL_PURGE;
                  cal_secs_reg  <= 10'(PURGE_S);
               end
            end
            OXA_CAL_PURGE: begin
               if (key_press.f) begin
                  cal_state_reg <= OXA_CAL_IDLE;                       // see R15
               end else if (sec_tick_reg) begin
                  if (cal_secs_reg == 10'h001) begin
                     cal_state_reg <= OXA_CAL_SAMPLE;
                     cal_secs_reg  <= 10'(SAMPLE_S);
                  end else begin
                     cal_secs_reg <= cal_secs_reg - 10'h001;
                  end
               end
            end
            OXA_CAL_SAMPLE: begin
               if (key_press.f) begin
                  cal_state_reg <= OXA_CAL_IDLE;                       // see R20
               end else if (sec_tick_reg) begin
                  if (cal_secs_reg == 10'h001) begin
                     cal_state_reg <= OXA_CAL_IDLE;
                     cal_done_reg  <= 1'b1;
                  end else begin
                     cal_secs_reg <= cal_secs_reg - 10'h001;
                  end
               end
            end
            default: cal_state_reg <= OXA_CAL_IDLE;
         endcase
      end
   end

   assign cal_frozen = cal_state_reg != OXA_CAL_IDLE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_gas_prompt_reg  <= 1'b0;
         high_gas_prompt_reg <= 1'b0;
         cal_busy_reg        <= 1'b0;
         cal_purge_reg       <= 1'b0;
      end else begin
         low_gas_prompt_reg  <= cal_state_reg == OXA_CAL_PR_LO;         // see R18
         high_gas_prompt_reg <= cal_state_reg == OXA_CAL_PR_HI;         // see R19
         cal_busy_reg        <= cal_frozen;
         cal_purge_reg       <= cal_state_reg == OXA_CAL_PURGE;
      end
   end

   // prompts show the live value; purge and sample hold the last one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         disp_value_reg <= '0;
      end else if (meas_valid && (!cal_frozen || cal_state_reg == OXA_CAL_PR_LO
                                  || cal_state_reg == OXA_CAL_PR_HI)) begin
         disp_value_reg <= meas_value;                                 // see R16, R18, R19
      end
   end

   // ==========================================================
   // value alarms
   logic [1:0]                   alm_act_reg;
   logic [1:0]                   alm_clr_key;

   // up key clears alarm one, down key alarm two, unless used to start calibration
   assign alm_clr_key[0] = key_press.up & ~key_press.f;
   assign alm_clr_key[1] = key_press.down & ~key_press.f;

   for (genvar i = 0; i < 2; i++) begin : g_alm
      logic [oxa_pkg::VAL_W+oxa_pkg::HYST_W-1:0] prod;
      logic [oxa_pkg::VAL_W-1:0]                 margin;
      logic [oxa_pkg::VAL_W:0]                   back_lvl;
      logic                                      trig;
      logic                                      passed_back;
      logic [oxa_pkg::DLY_W-1:0]                 dly_reg;

      // margin is relative to the threshold, truncated to 0,01 vol-%
      assign prod   = (oxa_pkg::VAL_W+oxa_pkg::HYST_W)'(alm_cfg_reg[i].limit) *
                      (oxa_pkg::VAL_W+oxa_pkg::HYST_W)'(alm_cfg_reg[i].hyst);
      assign margin = oxa_pkg::VAL_W'(prod / (oxa_pkg::VAL_W+oxa_pkg::HYST_W)'(oxa_pkg::HYST_DIV));  // see R10
      assign back_lvl = alm_cfg_reg[i].high_type
                        ? {1'b0, alm_cfg_reg[i].limit} - {1'b0, margin}
                        : {1'b0, alm_cfg_reg[i].limit} + {1'b0, margin};
      assign trig = alm_cfg_reg[i].high_type ? (meas_value > alm_cfg_reg[i].limit)
                                             : (meas_value < alm_cfg_reg[i].limit);           // see R2
      assign passed_back = alm_cfg_reg[i].high_type
                           ? ({1'b0, meas_value} <= back_lvl)
                           : ({1'b0, meas_value} >= back_lvl);                                 // see R9

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            alm_act_reg[i] <= 1'b0;
            dly_reg        <= '0;
         end else if (alm_cfg_reg[i].mode == oxa_pkg::OXA_MODE_OFF) begin
            alm_act_reg[i] <= 1'b0;                                                           // see R8
            dly_reg        <= '0;
         end else if (!cal_frozen) begin                                                      // see R16
            case (alm_cfg_reg[i].mode)
               oxa_pkg::OXA_MODE_LATCH: begin
                  // a new trigger in the clearing cycle keeps the alarm set
                  if (meas_valid && trig) begin                                               // see R23
                     alm_act_reg[i] <= 1'b1;
                  end else if (alm_clr_key[i]) begin
                     alm_act_reg[i] <= 1'b0;                                                  // see R7
                  end
               end
               oxa_pkg::OXA_MODE_AUTO: begin
                  if (meas_valid && trig) begin
                     alm_act_reg[i] <= 1'b1;
                  end else if (meas_valid && passed_back) begin
                     alm_act_reg[i] <= 1'b0;                                                  // see R9
                  end
               end
               oxa_pkg::OXA_MODE_TIMED: begin
                  if (!alm_act_reg[i]) begin
                     if (meas_valid && trig) begin
                        alm_act_reg[i] <= 1'b1;
                        dly_reg        <= alm_cfg_reg[i].delay;
                     end
                  end else if (sec_tick_reg) begin
                     if (dly_reg <= oxa_pkg::DLY_W'(1)) begin
                        alm_act_reg[i] <= 1'b0;                                               // see R11
                        dly_reg        <= '0;
                     end else begin
                        dly_reg <= dly_reg - oxa_pkg::DLY_W'(1);
                     end
                  end
               end
               default: alm_act_reg[i] <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // relays and display indication
   logic [1:0]                   ind;

   for (genvar i = 0; i < 2; i++) begin : g_ind
      // latched alarms flash at the seconds rate; the relay stays steady
      assign ind[i] = row_shows_alarms & alm_act_reg[i] &
                      (alm_cfg_reg[i].mode != oxa_pkg::OXA_MODE_LATCH | blink_reg);           // see R4, R7, R22
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_reg                   <= 2'h0;
         first_alarm_indication_reg  <= 1'b0;
         second_alarm_indication_reg <= 1'b0;
      end else begin
         relay_reg                   <= alm_act_reg;                  // see R3
         first_alarm_indication_reg  <= ind[0];                       // see R22
         second_alarm_indication_reg <= ind[1];
      end
   end

endmodule

// ===== design/oxa_pkg.sv
// What this block does
// R1 - two independent alarms, limit 0,2 to 25 vol-%
// R2 - high type above limit, low below
// R3 - each active alarm drives own relay
// R4 - display indication only when row shows alarms
// R5 - limit/type editing times out after 5 min
// R6 - four reset behaviours in protected level
// R7 - latching flashes; up clears one, down two
// R8 - alarm off behaviour never asserts
// R9 - self-clear after value passes back by margin
// R10 - margin 0,1 to 10 percent of threshold
// R11 - timed clear after preset delay
// R12 - delay whole seconds 1 to 60
// R13 - protected level falls back after 10 min
// R14 - in-range values accepted without confirmation
// R15 - function key aborts calibration, nothing else
// R16 - calibration freezes alarms, outputs and display (the display stays live in the low and high gas prompts)
// R17 - refuse setpoints with upper/lower ratio below 5
// R18 - down held plus function starts low point
// R19 - up held plus function starts high point
// R20 - function key after purge aborts calibration
// R21 - operator should do low point first
// R22 - alarm row shows whichever alarms are active
// R23 - compare on each new value, same units
package oxa_pkg;
   // concentrations are in units of 0,01 vol-%
   localparam int VAL_W           = 12;
   localparam int HYST_W          = 7;   // units of 0,1 percent relative
   localparam int DLY_W           = 6;   // whole seconds
   localparam int SEC_W           = 10;
   localparam logic [VAL_W-1:0]  LIMIT_MIN = 12'h014;  // 0,20 vol-%
   localparam logic [VAL_W-1:0]  LIMIT_MAX = 12'h9C4;  // 25,00 vol-%
   localparam logic [HYST_W-1:0] HYST_MIN  = 7'h01;    // 0,1 %
   localparam logic [HYST_W-1:0] HYST_MAX  = 7'h64;    // 10,0 %
   localparam logic [DLY_W-1:0]  DLY_MIN   = 6'h01;
   localparam logic [DLY_W-1:0]  DLY_MAX   = 6'h3C;
   localparam int HYST_DIV        = 1000;
   localparam int CAL_RATIO       = 5;
   localparam int EDIT_TIMEOUT_MIN = 5;
   localparam int PROT_TIMEOUT_MIN = 10;
   localparam logic [SEC_W-1:0] EDIT_TIMEOUT_S = SEC_W'(EDIT_TIMEOUT_MIN * 60);
   localparam logic [SEC_W-1:0] PROT_TIMEOUT_S = SEC_W'(PROT_TIMEOUT_MIN * 60);
   localparam int CLK_HZ          = 40_000_000;
   localparam int PURGE_S         = 30;
   localparam int SAMPLE_S        = 30;

   typedef enum logic [1:0] {
      OXA_MODE_LATCH = 2'h0,
      OXA_MODE_OFF   = 2'h1,
      OXA_MODE_AUTO  = 2'h2,
      OXA_MODE_TIMED = 2'h3
   } oxa_mode_t;

   typedef struct packed {
      logic [VAL_W-1:0]  limit;
      logic              high_type;
      oxa_mode_t         mode;
      logic [HYST_W-1:0] hyst;
      logic [DLY_W-1:0]  delay;
   } oxa_alm_cfg_t;

   localparam oxa_alm_cfg_t ALM_CFG_RST = '{limit: 12'h9C4, high_type: 1'b1, mode: OXA_MODE_AUTO,
                                            hyst: 7'h0A, delay: 6'h01};
   localparam logic [VAL_W-1:0] CAL_LOW_RST  = 12'h0C8;   // 2,00
   localparam logic [VAL_W-1:0] CAL_HIGH_RST = 12'h82F;   // 20,95

   typedef struct packed {
      logic f;
      logic up;
      logic down;
      logic hidden;
   } oxa_keys_t;
endpackage

// ===== dv/oxa_alarm_cal_chk.sv
`timescale 1ns/10ps
module oxa_alarm_cal_chk (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire oxa_pkg::oxa_keys_t    key_press,
   input wire oxa_pkg::oxa_keys_t    key_held,
   input wire logic                  cal_set_wr,
   input wire logic [11:0]           cal_low_in,
   input wire logic [11:0]           cal_high_in,
   input wire logic                  row_shows_alarms,
   input wire logic [1:0]            relay_reg,
   input wire logic                  first_alarm_indication_reg,
   input wire logic                  second_alarm_indication_reg,
   input wire logic [11:0]           disp_value_reg,
   input wire logic                  low_gas_prompt_reg,
   input wire logic                  high_gas_prompt_reg,
   input wire logic                  cal_busy_reg,
   input wire logic                  cal_purge_reg,
   input wire logic                  cfg_refused_reg,
   input wire logic [11:0]           cal_low_reg,
   input wire logic [11:0]           cal_high_reg,
   input wire oxa_pkg::oxa_alm_cfg_t alm_cfg_reg [2]
);
   logic [14:0] low_x5;
   assign low_x5 = 15'(cal_low_in) * 15'h5;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // sequences
   // busy lags the state by a cycle, hence the past-press guard
   sequence idle_f_s;
      key_press.f && !cal_busy_reg && !$past(key_press.f);
   endsequence
   sequence off2_s;
      (alm_cfg_reg[1].mode == oxa_pkg::OXA_MODE_OFF) [*3];
   endsequence
   // ==========================================
   // assertions
   low_start_a: assert property (idle_f_s ##0 key_held.down |-> ##2 low_gas_prompt_reg && cal_busy_reg)
      else $error("low prompt missing");
   high_start_a: assert property (idle_f_s ##0 key_held.up && !key_held.down |-> ##2 high_gas_prompt_reg)
      else $error("high prompt missing");
   prompt_busy_a: assert property (low_gas_prompt_reg || high_gas_prompt_reg || cal_purge_reg |-> cal_busy_reg)
      else $error("cal state without busy");
   cal_freeze_a: assert property (cal_purge_reg && $past(cal_purge_reg) |-> $stable(relay_reg) && $stable(disp_value_reg))
      else $error("outputs moved in cal");
   ratio_refuse_a: assert property (cal_set_wr && 15'(cal_high_in) < low_x5 |=> cfg_refused_reg && $stable(cal_high_reg))
      else $error("bad ratio accepted");
   ratio_accept_a: assert property (cal_set_wr && 15'(cal_high_in) >= low_x5 |=> cal_low_reg == $past(cal_low_in))
      else $error("good ratio dropped");
   off_quiet_a: assert property (off2_s |-> relay_reg[1] == 1'b0)
      else $error("alarm_off_behaviour alarm relay on");
   first_ind_a: assert property (first_alarm_indication_reg |-> relay_reg[0] && $past(row_shows_alarms))
      else $error("stray first indication");
   second_ind_a: assert property (second_alarm_indication_reg |-> relay_reg[1] && $past(row_shows_alarms))
      else $error("stray second indication");
endmodule
bind oxa_alarm_cal oxa_alarm_cal_chk u_chk (
   .clk, .rst_n, .key_press, .key_held, .cal_set_wr, .cal_low_in, .cal_high_in, .row_shows_alarms, .relay_reg,
   .first_alarm_indication_reg, .second_alarm_indication_reg, .disp_value_reg, .low_gas_prompt_reg,
   .high_gas_prompt_reg, .cal_busy_reg, .cal_purge_reg, .cfg_refused_reg, .cal_low_reg, .cal_high_reg, .alm_cfg_reg
);

// ===== dv/oxa_panel_model.sv
`timescale 1ns/10ps
module oxa_panel_model (
   input  wire logic         clk,
   input  wire logic [2:0]   cmd,
   output oxa_pkg::oxa_keys_t key_press,
   output oxa_pkg::oxa_keys_t key_held
);
   // ==========================================
   // one key at a time; a cursor key is held with f
   always @(posedge clk) begin
      key_press <= '0;
      key_held <= '0;
      case (cmd)
         3'h1: key_press.f <= 1'b1;
         3'h2: key_press.up <= 1'b1;
         3'h3: key_press.down <= 1'b1;
         3'h4: key_press.hidden <= 1'b1;
         3'h5: begin
            key_press.f <= 1'b1;
            key_held.down <= 1'b1;
         end
         3'h6: begin
            key_press.f <= 1'b1;
            key_held.up <= 1'b1;
         end
         default: ;
      endcase
   end
endmodule

// ===== dv/tb_oxa_alarm_cal.sv
`timescale 1ns/10ps
module tb_oxa_alarm_cal;
   logic clk = 1'b0, rst_n = 1'b0, meas_valid = 1'b0, edit_enter = 1'b0, cal_set_wr = 1'b0, row_shows_alarms = 1'b0;
   logic [11:0] meas_value = '0, cal_low_in = '0, cal_high_in = '0;
   logic [2:0] cmd = 3'h0;
   logic [1:0] cfg_wr = 2'h0;
   oxa_pkg::oxa_alm_cfg_t cfg_data = '0;
   oxa_pkg::oxa_keys_t key_press, key_held;
   logic [1:0] relay_reg;
   logic first_alarm_indication_reg, second_alarm_indication_reg, edit_active_reg, prot_level_reg;
   logic low_gas_prompt_reg, high_gas_prompt_reg, cal_busy_reg, cal_purge_reg, cal_done_reg, cfg_refused_reg;
   logic [11:0] disp_value_reg, cal_low_reg, cal_high_reg;
   oxa_pkg::oxa_alm_cfg_t alm_cfg_reg [2];
   int n_mismatch = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   // short second so the timeouts fit in the run
   oxa_alarm_cal #(.SEC_CYCLES(4), .PURGE_S(8), .SAMPLE_S(8)) u_oxa_alarm_cal (
      .clk, .rst_n, .meas_value, .meas_valid, .key_press, .key_held, .edit_enter, .cfg_wr, .cfg_data,
      .cal_set_wr, .cal_low_in, .cal_high_in, .row_shows_alarms, .relay_reg, .first_alarm_indication_reg,
      .second_alarm_indication_reg, .disp_value_reg, .edit_active_reg, .prot_level_reg, .low_gas_prompt_reg,
      .high_gas_prompt_reg, .cal_busy_reg, .cal_purge_reg, .cal_done_reg, .cfg_refused_reg, .cal_low_reg,
      .cal_high_reg, .alm_cfg_reg
   );
   oxa_panel_model u_oxa_panel_model (.clk, .cmd, .key_press, .key_held);
   // ==========================================
   // helpers
   task automatic chk(input logic [27:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic key(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
      wait_n(3);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic meas(input logic [11:0] v);
      @(posedge clk);
      meas_value <= v;
      meas_valid <= 1'b1;
      @(posedge clk);
      meas_valid <= 1'b0;
      wait_n(2);
   endtask
   task automatic cfg(input logic i, input oxa_pkg::oxa_alm_cfg_t c);
      @(posedge clk);
      cfg_data <= c;
      cfg_wr <= i ? 2'h2 : 2'h1;
      @(posedge clk);
      cfg_wr <= 2'h0;
      #1;
   endtask
   task automatic calset(input logic [11:0] lo, hi);
      @(posedge clk);
      cal_low_in <= lo;
      cal_high_in <= hi;
      cal_set_wr <= 1'b1;
      @(posedge clk);
      cal_set_wr <= 1'b0;
      #1;
   endtask
   task automatic edit_on();
      @(posedge clk);
      edit_enter <= 1'b1;
      @(posedge clk);
      edit_enter <= 1'b0;
   endtask
   // ==========================================
   // scenarios
   task automatic t_cfg();
      oxa_pkg::oxa_alm_cfg_t c, bad;
      chk(alm_cfg_reg[1], oxa_pkg::ALM_CFG_RST);
      chk(cal_high_reg, 12'h82F);
      key(3'h4);
      edit_on();
      chk(prot_level_reg, 1'b1);
      c = '{12'h014, 1'b1, oxa_pkg::OXA_MODE_LATCH, 7'h64, 6'h3C};
      cfg(1'b0, c);
      chk(alm_cfg_reg[0], c);
      bad = c;
      bad.limit = 12'h9C5;
      cfg(1'b0, bad);
      chk(alm_cfg_reg[0], c);
      c.limit = 12'h0C8;
      cfg(1'b0, c);
      c.mode = oxa_pkg::OXA_MODE_OFF;
      cfg(1'b1, c);
      chk(alm_cfg_reg[1], c);
      $display("t_cfg done");
   endtask
   task automatic t_latch();
      meas(12'h0C9);
      chk(relay_reg, 2'h1);
      chk(first_alarm_indication_reg, 1'b0);
      meas(12'h0C8);
      key(3'h3);
      chk(relay_reg, 2'h1);
      key(3'h2);
      chk(relay_reg, 2'h0);
      $display("t_latch done");
   endtask
   task automatic t_auto();
      oxa_pkg::oxa_alm_cfg_t a = '{12'h3E8, 1'b0, oxa_pkg::OXA_MODE_AUTO, 7'h64, 6'h01};
      @(posedge clk);
      row_shows_alarms <= 1'b1;
      cfg(1'b0, a);
      cfg(1'b1, a);
      meas(12'h3E7);
      chk(relay_reg, 2'h3);
      chk({first_alarm_indication_reg, second_alarm_indication_reg}, 2'h3);
      meas(12'h44B);
      chk(relay_reg, 2'h3);
      meas(12'h44C);
      chk(relay_reg, 2'h0);
      a.mode = oxa_pkg::OXA_MODE_OFF;
      cfg(1'b1, a);
      $display("t_auto done");
   endtask
   task automatic t_timed();
      cfg(1'b0, '{12'h0C8, 1'b1, oxa_pkg::OXA_MODE_TIMED, 7'h0A, 6'h02});
      meas(12'h0C9);
      wait_n(2);
      chk(relay_reg, 2'h1);
      wait_n(8);
      chk(relay_reg, 2'h0);
      $display("t_timed done");
   endtask
   task automatic t_cal();
      calset(12'h0C8, 12'h3E7);
      chk(cfg_refused_reg, 1'b1);
      calset(12'h0C8, 12'h3E8);
      chk(cal_high_reg, 12'h3E8);
      cfg(1'b0, '{12'h0C8, 1'b1, oxa_pkg::OXA_MODE_LATCH, 7'h0A, 6'h01});
      meas(12'h0C9);
      key(3'h5);
      chk(low_gas_prompt_reg, 1'b1);
      meas(12'h123);
      chk(disp_value_reg, 12'h123);
      key(3'h1);
      meas(12'h0B0);
      key(3'h2);
      chk({disp_value_reg, relay_reg}, {12'h123, 2'h1});
      for (int i = 0; i < 80 && cal_purge_reg; i++) wait_n(1);
      chk(cal_busy_reg, 1'b1);
      key(3'h1);
      chk(cal_busy_reg, 1'b0);
      key(3'h2);
      chk(relay_reg, 2'h0);
      key(3'h6);
      chk(high_gas_prompt_reg, 1'b1);
      key(3'h1);
      for (int i = 0; i < 120 && cal_done_reg !== 1'b1; i++) wait_n(1);
      chk(cal_done_reg, 1'b1);
      $display("t_cal done");
   endtask
   task automatic t_timeout();
      edit_on();
      key(3'h2);
      wait_n(1170);
      chk(edit_active_reg, 1'b1);
      wait_n(40);
      chk({edit_active_reg, prot_level_reg}, 2'h1);
      wait_n(1200);
      chk(prot_level_reg, 1'b0);
      $display("t_timeout done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_cfg();
      t_latch();
      t_auto();
      t_timed();
      t_cal();
      t_timeout();
      final_report();
   end
   initial begin
      repeat (8000) @(posedge clk);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule
